//--- design/ssrp_top.sv
// sensor serial register port: two-wire and spi slave front end over the register file
`timescale 1ns/1ps
`default_nettype none
`include "ssrp_consts.svh"

module ssrp_top
  import ssrp_pkg::*;
#(
  parameter int POWERUP_CYCLES = `SSRP_POWERUP_CYCLES
)(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        spi_select_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_n_o,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_sdi_i,
  output var  logic        spi_sdi_o,
  output var  logic        spi_sdi_oe_n_o,
  output var  logic        spi_sdo_o,
  output var  logic        spi_sdo_oe_n_o,
  input  wire logic        meas_valid_i,
  input  wire logic [15:0] meas_x_i,
  input  wire logic [15:0] meas_y_i,
  input  wire logic [15:0] meas_z_i,
  output var  logic        meas_trigger_o,
  output var  logic        cont_mode_o,
  output var  logic        result_ready_pin_o,
  output var  logic [7:0]  meas_config_o,
  output var  logic [7:0]  gain_config_o
);

  //--------------------------------------------------------------------------
  // pin synchronisers and edge detection
  //--------------------------------------------------------------------------

  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] prev_r;
  logic [5:0] pins;
  logic       scl_h, sda_h, cs_h, sck_h, sdi_h, spi_mode;
  logic       scl_rise, scl_fall, sda_rise, sda_fall, sck_rise, sck_fall;
  logic       i2c_start, i2c_stop;

  assign pins = {spi_select_i, spi_sdi_i, spi_sck_i, spi_cs_n_i, sda_i, scl_i};

  // two flops per pin, a third copy for edges
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 6'h3F;
      sync2_r <= 6'h3F;
      prev_r  <= 6'h3F;
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign {spi_mode, sdi_h, sck_h, cs_h, sda_h, scl_h} = sync2_r;
  assign scl_rise  = scl_h & ~prev_r[0];
  assign scl_fall  = ~scl_h & prev_r[0];
  assign sda_rise  = sda_h & ~prev_r[1];
  assign sda_fall  = ~sda_h & prev_r[1];
  assign sck_rise  = sck_h & ~prev_r[3];
  assign sck_fall  = ~sck_h & prev_r[3];
  assign i2c_start = sda_fall & scl_h & prev_r[0];
  assign i2c_stop  = sda_rise & scl_h & prev_r[0];

  //--------------------------------------------------------------------------
  // two-wire slave sequencer
  //--------------------------------------------------------------------------

  ssrp_i2c_state_t i2c_st_r,    i2c_st_nxt;
  ssrp_byte_t      i2c_sh_r,    i2c_sh_nxt;
  logic [3:0]      i2c_cnt_r,   i2c_cnt_nxt;
  logic            i2c_rw_r,    i2c_rw_nxt;
  logic            i2c_first_r, i2c_first_nxt;
  logic            i2c_more_r,  i2c_more_nxt;
  logic            i2c_rel_r,   i2c_rel_nxt;
  logic            i2c_load, i2c_wr, i2c_rd;

  ssrp_acc_if acc ();

  // bits are taken on scl rise, the slave changes sda only on scl fall
  always_comb
  begin
    i2c_st_nxt    = i2c_st_r;
    i2c_sh_nxt    = i2c_sh_r;
    i2c_cnt_nxt   = i2c_cnt_r;
    i2c_rw_nxt    = i2c_rw_r;
    i2c_first_nxt = i2c_first_r;
    i2c_more_nxt  = i2c_more_r;
    i2c_rel_nxt   = i2c_rel_r;
    i2c_load      = 1'b0;
    i2c_wr        = 1'b0;
    i2c_rd        = 1'b0;
    if (spi_mode)
    begin
      i2c_st_nxt  = SSRP_I2C_IDLE;
      i2c_rel_nxt = 1'b1;
    end
    else if (i2c_start)
    begin
      i2c_st_nxt    = SSRP_I2C_ADDR;
      i2c_cnt_nxt   = 4'h0;
      i2c_first_nxt = 1'b1;
      i2c_rel_nxt   = 1'b1;
    end
    else if (i2c_stop)
    begin
      i2c_st_nxt  = SSRP_I2C_IDLE;
      i2c_rel_nxt = 1'b1;
    end
    else
    begin
      unique case (i2c_st_r)
        SSRP_I2C_IDLE: ;
        SSRP_I2C_ADDR, SSRP_I2C_WDATA:
        begin
          if (scl_rise && i2c_cnt_r != 4'h8)
          begin
            i2c_sh_nxt  = {i2c_sh_r[6:0], sda_h};
            i2c_cnt_nxt = 4'(i2c_cnt_r + 4'h1);
          end
          else if (scl_fall && i2c_cnt_r == 4'h8)
          begin
            if (i2c_st_r == SSRP_I2C_ADDR)
            begin
              if (i2c_sh_r == `SSRP_I2C_ADDR_WR || i2c_sh_r == `SSRP_I2C_ADDR_RD)
              begin
                i2c_rw_nxt  = i2c_sh_r[0];
                i2c_rel_nxt = 1'b0;
                i2c_st_nxt  = SSRP_I2C_ACK;
              end
              else
                i2c_st_nxt = SSRP_I2C_IDLE;
            end
            else
            begin
              i2c_load      = i2c_first_r;
              i2c_wr        = ~i2c_first_r;
              i2c_first_nxt = 1'b0;
              i2c_rel_nxt   = 1'b0;
              i2c_st_nxt    = SSRP_I2C_ACK;
            end
          end
        end
        SSRP_I2C_ACK:
        begin
          if (scl_fall)
          begin
            i2c_cnt_nxt = 4'h0;
            if (i2c_rw_r)
            begin
              i2c_rd      = 1'b1;
              i2c_sh_nxt  = acc.rdata;
              i2c_rel_nxt = acc.rdata[7];
              i2c_st_nxt  = SSRP_I2C_RDATA;
            end
            else
            begin
              i2c_rel_nxt = 1'b1;
              i2c_st_nxt  = SSRP_I2C_WDATA;
            end
          end
        end
        SSRP_I2C_RDATA:
        begin
          if (scl_rise)
            i2c_cnt_nxt = 4'(i2c_cnt_r + 4'h1);
          else if (scl_fall && i2c_cnt_r == 4'h8)
          begin
            i2c_rel_nxt = 1'b1;
            i2c_st_nxt  = SSRP_I2C_RACK;
          end
          else if (scl_fall)
            i2c_rel_nxt = i2c_sh_r[~i2c_cnt_r[2:0]];
        end
        SSRP_I2C_RACK:
        begin
          if (scl_rise)
            i2c_more_nxt = ~sda_h;
          else if (scl_fall && i2c_more_r)
          begin
            i2c_cnt_nxt = 4'h0;
            i2c_rd      = 1'b1;
            i2c_sh_nxt  = acc.rdata;
            i2c_rel_nxt = acc.rdata[7];
            i2c_st_nxt  = SSRP_I2C_RDATA;
          end
          else if (scl_fall)
            i2c_st_nxt = SSRP_I2C_IDLE;
        end
      endcase
    end
  end

  // two-wire register stage
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      i2c_st_r    <= SSRP_I2C_IDLE;
      i2c_sh_r    <= 8'h00;
      i2c_cnt_r   <= 4'h0;
      i2c_rw_r    <= 1'b0;
      i2c_first_r <= 1'b0;
      i2c_more_r  <= 1'b0;
      i2c_rel_r   <= 1'b1;
    end
    else
    begin
      i2c_st_r    <= i2c_st_nxt;
      i2c_sh_r    <= i2c_sh_nxt;
      i2c_cnt_r   <= i2c_cnt_nxt;
      i2c_rw_r    <= i2c_rw_nxt;
      i2c_first_r <= i2c_first_nxt;
      i2c_more_r  <= i2c_more_nxt;
      i2c_rel_r   <= i2c_rel_nxt;
    end
  end

  //--------------------------------------------------------------------------
  // spi slave
  //--------------------------------------------------------------------------

  logic [2:0] spi_cnt_r,   spi_cnt_nxt;
  logic       spi_cmd_r,   spi_cmd_nxt;
  logic       spi_rw_r,    spi_rw_nxt;
  logic       spi_inc_r,   spi_inc_nxt;
  logic       spi_fetch_r, spi_fetch_nxt;
  ssrp_byte_t spi_sh_r,    spi_sh_nxt;
  ssrp_byte_t spi_tx_r,    spi_tx_nxt;
  logic       spi_out_r,   spi_out_nxt;
  logic       spi_drv_r,   spi_drv_nxt;
  logic       spi_load, spi_wr, spi_rd;
  ssrp_idx_t  spi_idx;
  ssrp_byte_t spi_byte;

  assign spi_idx  = {spi_sh_r[4:0], sdi_h};
  assign spi_byte = {spi_sh_r[6:0], sdi_h};

  // sample on sck rise, drive on sck fall, all framed by chip select
  always_comb
  begin
    spi_cnt_nxt   = spi_cnt_r;
    spi_cmd_nxt   = spi_cmd_r;
    spi_rw_nxt    = spi_rw_r;
    spi_inc_nxt   = spi_inc_r;
    spi_fetch_nxt = 1'b0;
    spi_sh_nxt    = spi_sh_r;
    spi_tx_nxt    = spi_tx_r;
    spi_out_nxt   = spi_out_r;
    spi_drv_nxt   = spi_drv_r;
    spi_load      = 1'b0;
    spi_wr        = 1'b0;
    spi_rd        = 1'b0;
    if (!spi_mode || cs_h)
    begin
      spi_cnt_nxt = 3'h0;
      spi_cmd_nxt = 1'b0;
      spi_drv_nxt = 1'b0;
    end
    else
    begin
      if (spi_fetch_r)
      begin
        spi_rd     = 1'b1;
        spi_tx_nxt = acc.rdata;
      end
      if (sck_rise)
      begin
        spi_sh_nxt  = spi_byte;
        spi_cnt_nxt = 3'(spi_cnt_r + 3'h1);
        if (spi_cnt_r == 3'h7 && !spi_cmd_r)
        begin
          spi_cmd_nxt   = 1'b1;
          spi_rw_nxt    = spi_sh_r[6];
          spi_inc_nxt   = spi_sh_r[5];
          spi_load      = 1'b1;
          spi_fetch_nxt = spi_sh_r[6];
        end
        else if (spi_cnt_r == 3'h7)
        begin
          spi_fetch_nxt = spi_rw_r;
          spi_wr        = ~spi_rw_r;
        end
      end
      if (sck_fall && spi_cmd_r && spi_rw_r)
      begin
        spi_drv_nxt = 1'b1;
        spi_out_nxt = spi_tx_r[~spi_cnt_r];
      end
    end
  end

  // spi register stage
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      spi_cnt_r   <= 3'h0;
      spi_cmd_r   <= 1'b0;
      spi_rw_r    <= 1'b0;
      spi_inc_r   <= 1'b0;
      spi_fetch_r <= 1'b0;
      spi_sh_r    <= 8'h00;
      spi_tx_r    <= 8'h00;
      spi_out_r   <= 1'b0;
      spi_drv_r   <= 1'b0;
    end
    else
    begin
      spi_cnt_r   <= spi_cnt_nxt;
      spi_cmd_r   <= spi_cmd_nxt;
      spi_rw_r    <= spi_rw_nxt;
      spi_inc_r   <= spi_inc_nxt;
      spi_fetch_r <= spi_fetch_nxt;
      spi_sh_r    <= spi_sh_nxt;
      spi_tx_r    <= spi_tx_nxt;
      spi_out_r   <= spi_out_nxt;
      spi_drv_r   <= spi_drv_nxt;
    end
  end

  //--------------------------------------------------------------------------
  // shared register access and pins
  //--------------------------------------------------------------------------

  // only one front end issues accesses at a time
  assign acc.ptr_load = spi_mode ? spi_load : i2c_load;
  assign acc.ptr_val  = spi_mode ? spi_idx : i2c_sh_r[5:0];
  assign acc.wr       = spi_mode ? spi_wr : i2c_wr;
  assign acc.rd       = spi_mode ? spi_rd : i2c_rd;
  assign acc.adv      = spi_mode ? spi_inc_r : 1'b1;
  assign acc.wdata    = spi_mode ? spi_byte : i2c_sh_r;

  ssrp_regfile #(
    .POWERUP_CYCLES (POWERUP_CYCLES)
  ) u_regs (
    .core_clk_i         (core_clk_i),
    .rst_i              (rst_i),
    .acc                (acc.regs),
    .meas_valid_i       (meas_valid_i),
    .meas_x_i           (meas_x_i),
    .meas_y_i           (meas_y_i),
    .meas_z_i           (meas_z_i),
    .meas_trigger_o     (meas_trigger_o),
    .cont_mode_o        (cont_mode_o),
    .result_ready_pin_o (result_ready_pin_o),
    .meas_config_o      (meas_config_o),
    .gain_config_o      (gain_config_o)
  );

  // open-drain data line and the two spi output routes
  assign sda_o          = 1'b0;
  assign sda_oe_n_o     = i2c_rel_r;
  assign spi_sdo_o      = spi_out_r;
  assign spi_sdi_o      = spi_out_r;
  assign spi_sdo_oe_n_o = ~(spi_drv_r & ~acc.three_wire);
  assign spi_sdi_oe_n_o = ~(spi_drv_r & acc.three_wire);

endmodule

`default_nettype wire

//--- design/ssrp_consts.svh
// constants of the sensor serial register port: addresses, indices, fields, timing
`ifndef SSRP_CONSTS_SVH
`define SSRP_CONSTS_SVH

// two-wire slave address and the address bytes it answers to
`define SSRP_I2C_SLAVE_ADDR 7'h1E
`define SSRP_I2C_ADDR_WR    {`SSRP_I2C_SLAVE_ADDR, 1'b0}
`define SSRP_I2C_ADDR_RD    {`SSRP_I2C_SLAVE_ADDR, 1'b1}

// register indices
`define SSRP_IDX_MEAS_CFG   6'h00
`define SSRP_IDX_GAIN_CFG   6'h01
`define SSRP_IDX_MODE       6'h02
`define SSRP_IDX_RES_FIRST  6'h03
`define SSRP_IDX_RES_LAST   6'h08
`define SSRP_IDX_STATUS     6'h09
`define SSRP_IDX_ID_A       6'h0A
`define SSRP_IDX_ID_B       6'h0B
`define SSRP_IDX_ID_C       6'h0C

// reset values
`define SSRP_MEAS_CFG_RST   8'h00
`define SSRP_GAIN_CFG_RST   8'h00
`define SSRP_MODE_RST       8'h01

// mode register fields
`define SSRP_MODE_CONT      2'h0
`define SSRP_MODE_SINGLE    2'h1
`define SSRP_MODE_3W_BIT    2

// status register fields
`define SSRP_STAT_LOCK_BIT  1
`define SSRP_STAT_RDY_BIT   0

// timing
`define SSRP_CLK_KHZ        50000
`define SSRP_POWERUP_MS     56
`define SSRP_POWERUP_CYCLES (`SSRP_POWERUP_MS * `SSRP_CLK_KHZ)

`endif

//--- design/ssrp_pkg.sv
// types of the sensor serial register port
package ssrp_pkg;

  // two-wire slave sequencer states
  typedef enum logic [5:0] {
    SSRP_I2C_IDLE  = 6'b000001,
    SSRP_I2C_ADDR  = 6'b000010,
    SSRP_I2C_ACK   = 6'b000100,
    SSRP_I2C_WDATA = 6'b001000,
    SSRP_I2C_RDATA = 6'b010000,
    SSRP_I2C_RACK  = 6'b100000
  } ssrp_i2c_state_t;

  typedef logic [7:0] ssrp_byte_t;
  typedef logic [5:0] ssrp_idx_t;

endpackage

//--- design/ssrp_acc_if.sv
// register access carrier between the bus front end and the register file
`timescale 1ns/1ps
`default_nettype none

interface ssrp_acc_if;
  import ssrp_pkg::*;

  logic       ptr_load;
  ssrp_idx_t  ptr_val;
  logic       wr;
  logic       rd;
  logic       adv;
  ssrp_byte_t wdata;
  ssrp_byte_t rdata;
  logic       three_wire;

  modport front (output ptr_load, output ptr_val, output wr, output rd, output adv, output wdata,
                 input rdata, input three_wire);
  modport regs  (input ptr_load, input ptr_val, input wr, input rd, input adv, input wdata,
                 output rdata, output three_wire);
endinterface

`default_nettype wire

//--- design/ssrp_regfile.sv
// register file: pointer, configuration, mode, result lock and power-up trigger
`timescale 1ns/1ps
`default_nettype none
`include "ssrp_consts.svh"

module ssrp_regfile
  import ssrp_pkg::*;
#(
  parameter int         POWERUP_CYCLES = `SSRP_POWERUP_CYCLES,
  parameter ssrp_byte_t ID_A_VAL       = 8'h5A, // arbitrary identification value
  parameter ssrp_byte_t ID_B_VAL       = 8'h5B, // arbitrary identification value
  parameter ssrp_byte_t ID_C_VAL       = 8'h5C  // arbitrary identification value
)(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  ssrp_acc_if.regs         acc,
  input  wire logic        meas_valid_i,
  input  wire logic [15:0] meas_x_i,
  input  wire logic [15:0] meas_y_i,
  input  wire logic [15:0] meas_z_i,
  output var  logic        meas_trigger_o,
  output var  logic        cont_mode_o,
  output var  logic        result_ready_pin_o,
  output var  logic [7:0]  meas_config_o,
  output var  logic [7:0]  gain_config_o
);

  ssrp_byte_t  meas_cfg_r, meas_cfg_nxt;
  ssrp_byte_t  gain_cfg_r, gain_cfg_nxt;
  ssrp_byte_t  mode_r,     mode_nxt;
  ssrp_byte_t  res_r [6];
  ssrp_byte_t  res_nxt [6];
  logic [5:0]  rd_mask_r,  rd_mask_nxt;
  logic        rdy_r,      rdy_nxt;
  ssrp_idx_t   ptr_r,      ptr_nxt;
  logic        trig_r,     trig_nxt;
  logic [31:0] pu_cnt_r,   pu_cnt_nxt;
  logic        pu_done_r,  pu_done_nxt;
  logic        locked;
  logic        in_res;
  logic [2:0]  res_sel;
  logic [47:0] meas_word;

  assign locked    = (|rd_mask_r) & ~(&rd_mask_r);
  assign in_res    = (ptr_r >= `SSRP_IDX_RES_FIRST) && (ptr_r <= `SSRP_IDX_RES_LAST);
  assign res_sel   = 3'(ptr_r - `SSRP_IDX_RES_FIRST);
  assign meas_word = {meas_x_i, meas_z_i, meas_y_i};

  // read data of the pointed register
  always_comb
  begin
    acc.rdata = 8'h00;
    unique case (ptr_r)
      `SSRP_IDX_MEAS_CFG: acc.rdata = meas_cfg_r;
      `SSRP_IDX_GAIN_CFG: acc.rdata = gain_cfg_r;
      `SSRP_IDX_MODE:     acc.rdata = mode_r;
      `SSRP_IDX_STATUS:   acc.rdata = {6'h00, locked, rdy_r};
      `SSRP_IDX_ID_A:     acc.rdata = ID_A_VAL;
      `SSRP_IDX_ID_B:     acc.rdata = ID_B_VAL;
      `SSRP_IDX_ID_C:     acc.rdata = ID_C_VAL;
      default:            acc.rdata = in_res ? res_r[res_sel] : 8'h00;
    endcase
  end

  assign acc.three_wire = mode_r[`SSRP_MODE_3W_BIT];

  // next state of pointer, registers, lock and trigger
  always_comb
  begin
    meas_cfg_nxt = meas_cfg_r;
    gain_cfg_nxt = gain_cfg_r;
    mode_nxt     = mode_r;
    res_nxt      = res_r;
    rd_mask_nxt  = rd_mask_r;
    rdy_nxt      = rdy_r;
    ptr_nxt      = ptr_r;
    trig_nxt     = 1'b0;
    pu_cnt_nxt   = pu_cnt_r;
    pu_done_nxt  = pu_done_r;
    // power-up delay, then the default single measurement
    if (!pu_done_r)
    begin
      pu_cnt_nxt = pu_cnt_r + 32'h1;
      if (pu_cnt_r == 32'(POWERUP_CYCLES - 1))
      begin
        pu_done_nxt = 1'b1;
        trig_nxt    = (mode_r[1:0] == `SSRP_MODE_SINGLE);
      end
    end
    // new results only when none or all six have been read
    if (meas_valid_i && !locked)
    begin
      for (int i = 0; i < 6; i++)
        res_nxt[i] = meas_word[47 - 8 * i -: 8];
      rd_mask_nxt = 6'h00;
    end
    if (acc.ptr_load)
      ptr_nxt = acc.ptr_val;
    if (acc.wr)
    begin
      unique case (ptr_r)
        `SSRP_IDX_MEAS_CFG:
        begin
          meas_cfg_nxt = acc.wdata;
          rd_mask_nxt  = 6'h00;
        end
        `SSRP_IDX_GAIN_CFG: gain_cfg_nxt = acc.wdata;
        `SSRP_IDX_MODE:
        begin
          mode_nxt    = acc.wdata;
          rd_mask_nxt = 6'h00;
          trig_nxt    = (acc.wdata[1:0] == `SSRP_MODE_SINGLE);
        end
        default: ;
      endcase
    end
    if (acc.rd && in_res)
      rd_mask_nxt[res_sel] = 1'b1;
    if ((acc.rd || acc.wr) && acc.adv)
      ptr_nxt = (ptr_r == `SSRP_IDX_RES_LAST) ? `SSRP_IDX_RES_FIRST : 6'(ptr_r + 6'h1);
    // ready clears once all six are read; a load in the same cycle wins
    if (&rd_mask_nxt)
      rdy_nxt = 1'b0;
    if (meas_valid_i && !locked)
      rdy_nxt = 1'b1;
  end

  // register stage
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      meas_cfg_r <= `SSRP_MEAS_CFG_RST;
      gain_cfg_r <= `SSRP_GAIN_CFG_RST;
      mode_r     <= `SSRP_MODE_RST;
      for (int i = 0; i < 6; i++)
        res_r[i] <= 8'h00;
      rd_mask_r  <= 6'h00;
      rdy_r      <= 1'b0;
      ptr_r      <= 6'h00;
      trig_r     <= 1'b0;
      pu_cnt_r   <= 32'h0;
      pu_done_r  <= 1'b0;
    end
    else
    begin
      meas_cfg_r <= meas_cfg_nxt;
      gain_cfg_r <= gain_cfg_nxt;
      mode_r     <= mode_nxt;
      res_r      <= res_nxt;
      rd_mask_r  <= rd_mask_nxt;
      rdy_r      <= rdy_nxt;
      ptr_r      <= ptr_nxt;
      trig_r     <= trig_nxt;
      pu_cnt_r   <= pu_cnt_nxt;
      pu_done_r  <= pu_done_nxt;
    end
  end

  assign meas_trigger_o     = trig_r;
  assign cont_mode_o        = (mode_r[1:0] == `SSRP_MODE_CONT);
  assign result_ready_pin_o = rdy_r;
  assign meas_config_o      = meas_cfg_r;
  assign gain_config_o      = gain_cfg_r;

endmodule

`default_nettype wire

//--- verif/ssrp_top_sva_chk_sva.sv
// pin timing checker of the serial register port
`timescale 1ns/1ps
`default_nettype none
module ssrp_top_sva (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic spi_select_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic sda_oe_n_o,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_n_o,
  input wire logic spi_sdi_oe_n_o,
  input wire logic meas_valid_i,
  input wire logic meas_trigger_o,
  input wire logic result_ready_pin_o
);
  // ----------
  // pin rules
  // ----------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_sda_spi_quiet: assert property (spi_select_i [*8] |-> sda_oe_n_o)
    else $error("sda driven in spi mode");
  a_spi_i2c_quiet: assert property (!spi_select_i [*8] |-> spi_sdo_oe_n_o && spi_sdi_oe_n_o)
    else $error("spi driven in two-wire mode");
  a_cs_release: assert property (spi_cs_n_i [*5] |-> spi_sdo_oe_n_o)
    else $error("sdo driven without select");
  a_sdo_start: assert property ($fell(spi_sdo_oe_n_o) |-> !$past(spi_cs_n_i, 3))
    else $error("sdo enabled outside frame");
  a_sdo_hold: assert property ($rose(spi_sck_i) && !spi_sdo_oe_n_o |=> $stable(spi_sdo_o) [*3])
    else $error("sdo moved while clock high");
  a_no_dual: assert property (spi_sdo_oe_n_o || spi_sdi_oe_n_o)
    else $error("both data lines driven");
  a_trig_pulse: assert property (meas_trigger_o |=> !meas_trigger_o)
    else $error("trigger longer than one cycle");
  a_rdy_cause: assert property ($rose(result_ready_pin_o) |-> $past(meas_valid_i) || $past(meas_valid_i, 2))
    else $error("ready without new result");
  c_ack: cover property ($fell(sda_oe_n_o));
  c_sdo: cover property ($fell(spi_sdo_oe_n_o));
  c_three: cover property ($fell(spi_sdi_oe_n_o));
  c_trig: cover property (meas_trigger_o);
endmodule
bind ssrp_top ssrp_top_sva ssrp_top_sva_inst (.*);
`default_nettype wire

//--- verif/ssrp_host.sv
// host master model on the two-wire and spi pins
`timescale 1ns/1ps
`default_nettype none
module ssrp_host (
  input  wire logic core_clk_i,
  input  wire logic sda_o,
  input  wire logic sda_oe_n_o,
  input  wire logic spi_sdo_o,
  input  wire logic spi_sdo_oe_n_o,
  input  wire logic spi_sdi_o,
  input  wire logic spi_sdi_oe_n_o,
  output var  logic scl_i,
  output var  logic sda_i,
  output var  logic spi_cs_n_i,
  output var  logic spi_sck_i,
  output var  logic spi_sdi_i
);
  logic       sda_m;
  logic       sdo_line;
  logic       tw;
  logic [7:0] d [8];
  // -------------------------
  // pins and bus cycle tasks
  // -------------------------
  // pulled-up data line; a released read line shows inverted data; tw reads the shared line
  assign sda_i = sda_m & (sda_oe_n_o | sda_o);
  assign sdo_line = tw ? spi_sdi_o ^ spi_sdi_oe_n_o : spi_sdo_o ^ spi_sdo_oe_n_o;
  initial
  begin
    tw = 1'b0;
    sda_m = 1'b1;
    scl_i = 1'b1;
    spi_cs_n_i = 1'b1;
    spi_sck_i = 1'b1;
    spi_sdi_i = 1'b1;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // frame of 16 plus 8 per extra byte, change on fall, sample on rise
  task automatic spi(input logic [7:0] c, input int n);
    spi_cs_n_i = 1'b0;
    hp(4);
    for (int i = 0; i < 8 * (n + 1); i++)
    begin
      spi_sck_i = 1'b0;
      spi_sdi_i = (i < 8) ? c[7 - i] : d[i / 8 - 1][7 - i % 8];
      hp(4);
      if (i >= 8) d[i / 8 - 1][7 - i % 8] = sdo_line;
      spi_sck_i = 1'b1;
      hp(4);
    end
    spi_cs_n_i = 1'b1;
    hp(8);
  endtask
  task automatic i2c_start();
    sda_m = 1'b1;
    hp(6);
    scl_i = 1'b1;
    hp(8);
    sda_m = 1'b0;
    hp(8);
    scl_i = 1'b0;
    hp(2);
  endtask
  task automatic i2c_stop();
    sda_m = 1'b0;
    hp(6);
    scl_i = 1'b1;
    hp(8);
    sda_m = 1'b1;
    hp(8);
  endtask
  // eight bits then the acknowledge slot
  task automatic i2c_byte(input logic [7:0] b, input logic m, output logic [7:0] r, output logic a);
    for (int i = 8; i >= 0; i--)
    begin
      sda_m = (i > 0) ? b[i - 1] : m;
      hp(6);
      if (i > 0) r[i - 1] = sda_i;
      else a = sda_i;
      scl_i = 1'b1;
      hp(8);
      scl_i = 1'b0;
      hp(2);
    end
  endtask
endmodule
`default_nettype wire

//--- verif/test_sensor_serial_register_port.sv
// self-checking bench of the serial register port
`timescale 1ns/1ps
`default_nettype none
module test_sensor_serial_register_port;
  logic        core_clk_i, rst_i, spi_select_i, meas_valid_i, scl_i, sda_i, sda_o, sda_oe_n_o;
  logic        spi_cs_n_i, spi_sck_i, spi_sdi_i, spi_sdi_o, spi_sdi_oe_n_o, spi_sdo_o, spi_sdo_oe_n_o;
  logic        meas_trigger_o, cont_mode_o, result_ready_pin_o;
  logic [15:0] meas_x_i, meas_y_i, meas_z_i;
  logic [7:0]  meas_config_o, gain_config_o;
  int          n_errors = 0;
  int          check_count = 0;
  int          trig = 0;
  ssrp_top #(.POWERUP_CYCLES(50)) ssrp_top_inst (.*);
  ssrp_host ssrp_host_inst (.*);
  // -----------------
  // helpers and tests
  // -----------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // result byte k in register order x, z, y, high byte first
  function automatic logic [7:0] res(input logic [47:0] v, input int k);
    return v[47 - 8 * k -: 8];
  endfunction
  task automatic pulse(input logic [47:0] v);
    {meas_x_i, meas_z_i, meas_y_i} = v;
    meas_valid_i = 1'b1;
    @(posedge core_clk_i);
    #1 meas_valid_i = 1'b0;
  endtask
  task automatic rd6(input logic [47:0] v);
    ssrp_host_inst.spi(8'hC3, 6);
    for (int i = 0; i < 6; i++) chk(ssrp_host_inst.d[i], res(v, i));
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (meas_trigger_o === 1'b1) trig <= trig + 1;
  // watchdog well beyond the few thousand cycles the tests need
  initial
  begin
    repeat (60000) @(posedge core_clk_i);
    n_errors++;
    summarize();
  end
  initial
  begin
    logic [47:0] v;
    logic [7:0]  g, r;
    logic        a;
    void'($urandom(32'h8A323776));
    {rst_i, spi_select_i, meas_valid_i} = 3'h6;
    {meas_x_i, meas_y_i, meas_z_i} = 48'h0;
    repeat (5) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    ssrp_host_inst.hp(3);
    g = 8'($urandom);
    ssrp_host_inst.d[0] = g;
    ssrp_host_inst.spi(8'h01, 1);
    chk(gain_config_o, g);
    ssrp_host_inst.d[0] = ~g;
    ssrp_host_inst.d[1] = g ^ 8'h5A;
    ssrp_host_inst.spi(8'h40, 2);
    chk(meas_config_o, ~g);
    chk(gain_config_o, g ^ 8'h5A);
    chk(8'(trig), 8'h01);
    ssrp_host_inst.spi(8'hCA, 3);
    for (int i = 0; i < 3; i++) chk(ssrp_host_inst.d[i], 8'h5A + 8'(i));
    ssrp_host_inst.spi(8'h8A, 2);
    chk(ssrp_host_inst.d[1], 8'h5A);
    $display("spi write and read done");
    v = 48'({$urandom, $urandom});
    pulse(v);
    chk({7'h00, result_ready_pin_o}, 8'h01);
    rd6(v);
    chk({7'h00, result_ready_pin_o}, 8'h00);
    ssrp_host_inst.d[0] = 8'h00;
    ssrp_host_inst.spi(8'h02, 1);
    chk({7'h00, cont_mode_o}, 8'h01);
    v = 48'({$urandom, $urandom});
    pulse(v);
    ssrp_host_inst.spi(8'h83, 1);
    pulse(~v);
    ssrp_host_inst.spi(8'h89, 1);
    chk(ssrp_host_inst.d[0], 8'h03);
    rd6(v);
    ssrp_host_inst.d[0] = 8'h01;
    ssrp_host_inst.spi(8'h02, 1);
    chk({7'h00, cont_mode_o}, 8'h00);
    chk(8'(trig), 8'h02);
    ssrp_host_inst.d[0] = 8'h04;
    ssrp_host_inst.spi(8'h02, 1);
    ssrp_host_inst.tw = 1'b1;
    ssrp_host_inst.spi(8'h8B, 1);
    chk(ssrp_host_inst.d[0], 8'h5B);
    $display("results and lock done");
    spi_select_i = 1'b0;
    ssrp_host_inst.hp(8);
    ssrp_host_inst.i2c_start();
    ssrp_host_inst.i2c_byte(8'h3C, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    ssrp_host_inst.i2c_byte(8'h01, 1'b1, r, a);
    ssrp_host_inst.i2c_byte(~g, 1'b1, r, a);
    ssrp_host_inst.i2c_stop();
    chk(gain_config_o, ~g);
    ssrp_host_inst.i2c_start();
    ssrp_host_inst.i2c_byte(8'h3C, 1'b1, r, a);
    ssrp_host_inst.i2c_byte(8'h0A, 1'b1, r, a);
    ssrp_host_inst.i2c_start();
    ssrp_host_inst.i2c_byte(8'h3D, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    ssrp_host_inst.i2c_byte(8'hFF, 1'b0, r, a);
    chk(r, 8'h5A);
    ssrp_host_inst.i2c_byte(8'hFF, 1'b1, r, a);
    chk(r, 8'h5B);
    ssrp_host_inst.i2c_stop();
    ssrp_host_inst.i2c_start();
    ssrp_host_inst.i2c_byte(8'h3E, 1'b1, r, a);
    chk({7'h00, a}, 8'h01);
    ssrp_host_inst.i2c_stop();
    $display("two-wire done");
    summarize();
  end
endmodule
`default_nettype wire
